// [rtl/pmc_pkg.sv]
/*
  Package for the power mode controller: power states, wake source and
  control carriers, timing counts, RAM bank sizes.
  Assumes one 125 MHz system clock and an active-low asynchronous reset.
*/
// Functional notes
// - run: gate clocks of idle peripherals
// - cpu halt: core stopped, peripherals, transfers on
// - cpu halt: enabled pin/peripheral interrupt wakes
// - retention halt: core off, RAM kept
// - retention halt: pins hold their entry state
// - retention halt entry: all oscillators off
// - retention halt wake skips system init
// - low-power timer runs, optional wake source
// - standby: same wake set, core off
// - standby: per-bank retention of four banks
// - off: everything off except front end power, which follows software; pin wake only
// - front end power follows software only
// - crystal oscillators follow power state automatically
// - wake pins: per-pin rising or falling edge
// - peripheral activity reopens its gated clock the next cycle
package pmc_pkg;

  localparam int unsigned PMC_NUM_PINS   = 23;
  localparam int unsigned PMC_NUM_PERIPH = 8;
  localparam int unsigned PMC_NUM_BANKS  = 4;

  // bank sizes in KB, without and with error correction
  localparam int unsigned PMC_BANK_A_KB  = 20;
  localparam int unsigned PMC_BANK_B_KB  = 20;
  localparam int unsigned PMC_BANK_C_KB  = 40;
  localparam int unsigned PMC_BANK_D_KB  = 80;
  localparam int unsigned PMC_BANK_A_ECC_KB = 16;
  localparam int unsigned PMC_BANK_B_ECC_KB = 16;
  localparam int unsigned PMC_BANK_C_ECC_KB = 32;
  localparam int unsigned PMC_BANK_D_ECC_KB = 64;

  // timing
  localparam int unsigned PMC_CLK_MHZ      = 125;
  localparam int unsigned PMC_INIT_NS      = 2000;
  localparam int unsigned PMC_INIT_CYC     = (PMC_INIT_NS * PMC_CLK_MHZ + 999) / 1000;
  localparam int unsigned PMC_RESUME_CYC   = 4;
  localparam int unsigned PMC_OSC_CYC      = 8;
  localparam int unsigned PMC_CNT_W        = 12;

  typedef enum logic [2:0] {
    PMC_MODE_RUN,
    PMC_MODE_CPU_HALT,
    PMC_MODE_RET_HALT,
    PMC_MODE_STANDBY,
    PMC_MODE_OFF
  } pmc_mode_t;

  typedef enum logic [2:0] {
    PMC_ST_RUN,
    PMC_ST_CPU_HALT,
    PMC_ST_OSC_DOWN,
    PMC_ST_LOW,
    PMC_ST_OSC_UP,
    PMC_ST_RESUME,
    PMC_ST_INIT
  } pmc_state_t;

  // power and clock controls driven to the chip
  typedef struct packed {
    logic                      cpu_clk_en;
    logic                      cpu_pwr_en;
    logic                      periph_pwr_en;
    logic [PMC_NUM_PERIPH-1:0] periph_clk_en;
    logic                      xfer_clk_en;
    logic                      osc_en;
    logic                      xtal_en;
    logic [PMC_NUM_BANKS-1:0]  bank_ret;
    logic                      pin_hold;
    logic                      lp_timer_run;
    logic                      afe_pwr_en;
    logic                      sys_init;
  } pmc_ctrl_t;

  // wake-relevant inputs
  typedef struct packed {
    logic [PMC_NUM_PINS-1:0]   pin_level;
    logic [PMC_NUM_PINS-1:0]   pin_wake_en;
    logic [PMC_NUM_PINS-1:0]   pin_fall;
    logic                      pin_irq;
    logic [PMC_NUM_PERIPH-1:0] periph_irq;
    logic [PMC_NUM_PERIPH-1:0] periph_irq_en;
    logic                      lp_timer_evt;
    logic                      lp_timer_wake_en;
  } pmc_wake_in_t;

endpackage

// [rtl/pmc_pin_wake.sv]
/*
  Per-pin edge wake detector.
  Assumes pin levels synchronous to the system clock.
*/
module pmc_pin_wake (
  // clock and reset
  input  wire logic                             i_clk_sys,
  input  wire logic                             i_rst_n,
  // pins
  input  wire logic [pmc_pkg::PMC_NUM_PINS-1:0] i_level,
  input  wire logic [pmc_pkg::PMC_NUM_PINS-1:0] i_wake_en,
  input  wire logic [pmc_pkg::PMC_NUM_PINS-1:0] i_fall,
  // result
  output logic                                  o_wake
);

  typedef struct packed {
    logic [pmc_pkg::PMC_NUM_PINS-1:0] prev;
  } pmc_pw_state_t;

  pmc_pw_state_t s_q;
  pmc_pw_state_t s_d;
  logic [pmc_pkg::PMC_NUM_PINS-1:0] hit;

  // per-pin edge select
  for (genvar g = 0; g < pmc_pkg::PMC_NUM_PINS; g++) begin : g_pin
    assign hit[g] = i_wake_en[g] & (i_fall[g] ? (s_q.prev[g] & ~i_level[g])
                                              : (~s_q.prev[g] & i_level[g]));
  end

  assign o_wake = |hit;

  always_comb begin
    s_d = s_q;
    s_d.prev = i_level;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// [rtl/pmc_clk_gate.sv]
/*
  Peripheral clock gating: when allowed, clocks on while a peripheral is requested or
  shows activity.
  Assumes request and activity synchronous to the system clock.
*/
module pmc_clk_gate (
  // clock and reset
  input  wire logic                               i_clk_sys,
  input  wire logic                               i_rst_n,
  // control
  input  wire logic                               i_allow,
  input  wire logic [pmc_pkg::PMC_NUM_PERIPH-1:0] i_req,
  input  wire logic [pmc_pkg::PMC_NUM_PERIPH-1:0] i_activity,
  // gates
  output logic      [pmc_pkg::PMC_NUM_PERIPH-1:0] o_clk_en
);

  typedef struct packed {
    logic [pmc_pkg::PMC_NUM_PERIPH-1:0] en;
  } pmc_cg_state_t;

  pmc_cg_state_t s_q;
  pmc_cg_state_t s_d;

  always_comb begin
    s_d = s_q;
    // idle peripherals gated, demand or activity reopens next cycle
    s_d.en = i_allow ? (i_req | i_activity) : '0;
  end

  assign o_clk_en = s_q.en;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// [rtl/pmc_power_mode_ctrl.sv]
/*
  Power mode controller: sequences run, cpu halt, retention halt,
  standby retention and off; drives power, clock, retention and hold
  controls and decides wake.
  Assumes synchronous inputs and a 125 MHz clock that keeps running in
  the controller's own always-on domain.
*/
module pmc_power_mode_ctrl (
  // clock and reset
  input  wire logic                               i_clk_sys,
  input  wire logic                               i_rst_n,
  // mode request from the core
  input  wire logic                               i_mode_req,
  input  wire pmc_pkg::pmc_mode_t                 i_mode_sel,
  input  wire logic [pmc_pkg::PMC_NUM_BANKS-1:0]  i_bank_ret_sel,
  input  wire logic                               i_afe_pwr_sw,
  input  wire logic                               i_lp_timer_on,
  // peripheral demand
  input  wire logic [pmc_pkg::PMC_NUM_PERIPH-1:0] i_periph_req,
  input  wire logic [pmc_pkg::PMC_NUM_PERIPH-1:0] i_periph_activity,
  // wake sources
  input  wire pmc_pkg::pmc_wake_in_t              i_wake,
  // controls
  output pmc_pkg::pmc_ctrl_t                      o_ctrl,
  output pmc_pkg::pmc_state_t                     o_state,
  output logic                                    o_wake_evt
);

  typedef struct packed {
    pmc_pkg::pmc_state_t              st;
    pmc_pkg::pmc_mode_t               mode;
    logic [pmc_pkg::PMC_CNT_W-1:0]    cnt;
    logic [pmc_pkg::PMC_NUM_BANKS-1:0] ret;
    logic                             afe;
    logic                             wake;
  } pmc_top_state_t;

  localparam logic [pmc_pkg::PMC_CNT_W-1:0] INIT_CNT   = pmc_pkg::PMC_CNT_W'(pmc_pkg::PMC_INIT_CYC - 1);
  localparam logic [pmc_pkg::PMC_CNT_W-1:0] RESUME_CNT = pmc_pkg::PMC_CNT_W'(pmc_pkg::PMC_RESUME_CYC - 1);
  localparam logic [pmc_pkg::PMC_CNT_W-1:0] OSC_CNT    = pmc_pkg::PMC_CNT_W'(pmc_pkg::PMC_OSC_CYC - 1);

  pmc_top_state_t s_q;
  pmc_top_state_t s_d;
  logic           pin_wake;
  logic           periph_wake;
  logic           timer_wake;
  logic           low_wake;
  logic           clk_allow;
  logic [pmc_pkg::PMC_NUM_PERIPH-1:0] gate_en;

  pmc_pin_wake u_pin_wake (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_level   (i_wake.pin_level),
    .i_wake_en (i_wake.pin_wake_en),
    .i_fall    (i_wake.pin_fall),
    .o_wake    (pin_wake)
  );

  assign clk_allow = (s_q.st == pmc_pkg::PMC_ST_RUN) || (s_q.st == pmc_pkg::PMC_ST_CPU_HALT);

  pmc_clk_gate u_clk_gate (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_allow    (clk_allow),
    .i_req      (i_periph_req),
    .i_activity (i_periph_activity),
    .o_clk_en   (gate_en)
  );

  // cpu halt wake: enabled pin or peripheral interrupt
  assign periph_wake = i_wake.pin_irq | (|(i_wake.periph_irq & i_wake.periph_irq_en));
  // timer event counts only when enabled for wake
  assign timer_wake  = i_lp_timer_on & i_wake.lp_timer_wake_en & i_wake.lp_timer_evt;
  // retention halt and standby share one wake set; off takes pins only
  assign low_wake    = (s_q.mode == pmc_pkg::PMC_MODE_OFF) ? pin_wake
                                                           : (pin_wake | timer_wake);

  always_comb begin
    s_d      = s_q;
    s_d.wake = 1'h0;
    s_d.afe  = i_afe_pwr_sw;
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'h1;
    end
    unique case (s_q.st)
      pmc_pkg::PMC_ST_RUN: begin
        if (i_mode_req) begin
          s_d.mode = i_mode_sel;
          s_d.ret  = (i_mode_sel == pmc_pkg::PMC_MODE_STANDBY) ? i_bank_ret_sel : '1;
          if (i_mode_sel == pmc_pkg::PMC_MODE_CPU_HALT) begin
            s_d.st = pmc_pkg::PMC_ST_CPU_HALT;
          end else if (i_mode_sel != pmc_pkg::PMC_MODE_RUN) begin
            s_d.st  = pmc_pkg::PMC_ST_OSC_DOWN;
            s_d.cnt = OSC_CNT;
          end
        end
      end
      pmc_pkg::PMC_ST_CPU_HALT: begin
        if (periph_wake || pin_wake) begin
          s_d.st   = pmc_pkg::PMC_ST_RUN;
          s_d.mode = pmc_pkg::PMC_MODE_RUN;
          s_d.wake = 1'h1;
        end
      end
      pmc_pkg::PMC_ST_OSC_DOWN: begin
        if (s_q.cnt == '0) begin
          s_d.st = pmc_pkg::PMC_ST_LOW;
        end
      end
      pmc_pkg::PMC_ST_LOW: begin
        if (low_wake) begin
          s_d.st   = pmc_pkg::PMC_ST_OSC_UP;
          s_d.cnt  = OSC_CNT;
          s_d.wake = 1'h1;
        end
      end
      pmc_pkg::PMC_ST_OSC_UP: begin
        if (s_q.cnt == '0) begin
          if (s_q.mode == pmc_pkg::PMC_MODE_RET_HALT) begin
            s_d.st  = pmc_pkg::PMC_ST_RESUME;
            s_d.cnt = RESUME_CNT;
          end else begin
            s_d.st  = pmc_pkg::PMC_ST_INIT;
            s_d.cnt = INIT_CNT;
          end
        end
      end
      pmc_pkg::PMC_ST_RESUME,
      pmc_pkg::PMC_ST_INIT: begin
        if (s_q.cnt == '0) begin
          s_d.st   = pmc_pkg::PMC_ST_RUN;
          s_d.mode = pmc_pkg::PMC_MODE_RUN;
          s_d.ret  = '1;
        end
      end
      default: begin
        s_d.st = pmc_pkg::PMC_ST_INIT;
        s_d.cnt = INIT_CNT;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q.st   <= pmc_pkg::PMC_ST_INIT;
      s_q.mode <= pmc_pkg::PMC_MODE_RUN;
      s_q.cnt  <= INIT_CNT;
      s_q.ret  <= '1;
      s_q.afe  <= 1'h0;
      s_q.wake <= 1'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // output decode from registered state and the timer switch
  logic in_low;
  logic osc_off;
  logic deep;

  assign in_low  = (s_q.st == pmc_pkg::PMC_ST_OSC_DOWN) || (s_q.st == pmc_pkg::PMC_ST_LOW);
  assign osc_off = (s_q.st == pmc_pkg::PMC_ST_LOW);
  assign deep    = in_low || (s_q.st == pmc_pkg::PMC_ST_OSC_UP);

  always_comb begin
    o_ctrl               = '0;
    // core clock only in run
    o_ctrl.cpu_clk_en    = (s_q.st == pmc_pkg::PMC_ST_RUN);
    // core powered unless in a deep state
    o_ctrl.cpu_pwr_en    = !deep;
    o_ctrl.periph_pwr_en = !(deep && s_q.mode == pmc_pkg::PMC_MODE_OFF) &&
                           !(osc_off && s_q.mode != pmc_pkg::PMC_MODE_RET_HALT);
    o_ctrl.periph_clk_en = gate_en;
    o_ctrl.xfer_clk_en   = clk_allow;
    o_ctrl.osc_en        = !osc_off;
    o_ctrl.xtal_en       = !osc_off;
    // off keeps nothing; standby per bank; others keep all
    o_ctrl.bank_ret      = (s_q.mode == pmc_pkg::PMC_MODE_OFF) ? '0 : s_q.ret;
    o_ctrl.pin_hold      = deep && (s_q.mode == pmc_pkg::PMC_MODE_RET_HALT);
    o_ctrl.lp_timer_run  = i_lp_timer_on && (s_q.mode != pmc_pkg::PMC_MODE_OFF);
    o_ctrl.afe_pwr_en    = s_q.afe;
    o_ctrl.sys_init      = (s_q.st == pmc_pkg::PMC_ST_INIT);
  end

  assign o_state    = s_q.st;
  assign o_wake_evt = s_q.wake;

endmodule

// [tb/pmc_far_model.sv]
/*
  Far-side model: wake pins, low-power timer event, peripheral interrupts.
  Assumes the bench calls its tasks just after a clock edge.
*/
module pmc_far_model (
  // clock
  input  wire logic             i_clk_sys,
  // wake sources
  output pmc_pkg::pmc_wake_in_t o_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_wake = '0;
  // pin edge of chosen direction
  task automatic pin_edge(input int p, input logic f);
    @(posedge i_clk_sys);
    o_wake.pin_wake_en[p] <= 1'h1;
    o_wake.pin_fall[p]    <= f;
    o_wake.pin_level[p]   <= f;
    @(posedge i_clk_sys);
    o_wake.pin_level[p]   <= ~f;
  endtask
  // one-cycle timer event
  task automatic tmr_evt;
    @(posedge i_clk_sys);
    o_wake.lp_timer_wake_en <= 1'h1;
    o_wake.lp_timer_evt     <= 1'h1;
    @(posedge i_clk_sys);
    o_wake.lp_timer_evt     <= 1'h0;
  endtask
  task automatic irq(input int n, input logic v, input logic e);
    @(posedge i_clk_sys);
    o_wake.periph_irq[n]    <= v;
    o_wake.periph_irq_en[n] <= e;
  endtask
endmodule

// [tb/pmc_chk.sv]
/*
  Checker for the power mode controller, bound to its top.
  Assumes the package's state codes and timing counts.
*/
module pmc_chk (
  // clock and reset
  input wire logic                  i_clk_sys,
  input wire logic                  i_rst_n,
  // inputs
  input wire logic                  i_mode_req,
  input wire pmc_pkg::pmc_mode_t    i_mode_sel,
  input wire logic [3:0]            i_bank_ret_sel,
  input wire logic                  i_afe_pwr_sw,
  input wire logic                  i_lp_timer_on,
  input wire logic [7:0]            i_periph_req,
  input wire logic [7:0]            i_periph_activity,
  input wire pmc_pkg::pmc_wake_in_t i_wake,
  // outputs
  input wire pmc_pkg::pmc_ctrl_t    o_ctrl,
  input wire pmc_pkg::pmc_state_t   o_state,
  input wire logic                  o_wake_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  pmc_pkg::pmc_mode_t mode_q;
  logic [3:0]         ret_q;
  logic               run;
  logic               low;
  logic               halt;
  assign run  = o_state == pmc_pkg::PMC_ST_RUN;
  assign low  = o_state == pmc_pkg::PMC_ST_LOW;
  assign halt = o_state == pmc_pkg::PMC_ST_CPU_HALT;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= pmc_pkg::PMC_MODE_RUN;
      ret_q  <= 4'h0;
    end else if (run && i_mode_req && i_mode_sel != pmc_pkg::PMC_MODE_RUN) begin
      mode_q <= i_mode_sel;
      ret_q  <= i_bank_ret_sel;
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_ret_take;
    run && i_mode_req && i_mode_sel == pmc_pkg::PMC_MODE_RET_HALT;
  endsequence
  sequence s_resume;
    o_state == pmc_pkg::PMC_ST_OSC_UP ##1 o_state == pmc_pkg::PMC_ST_RESUME;
  endsequence
  a_osc_down_seq: assert property (s_ret_take |=> (o_state == pmc_pkg::PMC_ST_OSC_DOWN) [*8] ##1 low)
    else $error("bad entry");
  a_resume_fast: assert property (s_resume |=> (o_state == pmc_pkg::PMC_ST_RESUME && !o_ctrl.sys_init) [*3] ##1 run)
    else $error("bad resume");
  a_init_held: assert property (o_state == pmc_pkg::PMC_ST_INIT |-> o_ctrl.sys_init && !o_ctrl.cpu_clk_en)
    else $error("bad init");
  a_halt_core_off: assert property (halt |-> !o_ctrl.cpu_clk_en && o_ctrl.periph_pwr_en && o_ctrl.xfer_clk_en)
    else $error("bad halt");
  a_halt_irq_wake: assert property (halt && |(i_wake.periph_irq & i_wake.periph_irq_en) |=> run)
    else $error("no halt wake");
  a_low_osc_off: assert property (low |-> !o_ctrl.osc_en && !o_ctrl.xtal_en &&
    o_ctrl.lp_timer_run == (i_lp_timer_on && mode_q != pmc_pkg::PMC_MODE_OFF))
    else $error("osc on");
  a_ret_keep: assert property (low && mode_q == pmc_pkg::PMC_MODE_RET_HALT |-> o_ctrl.pin_hold && o_ctrl.bank_ret == 4'hF && !o_ctrl.cpu_pwr_en)
    else $error("bad retention");
  a_stby_banks: assert property (low && mode_q == pmc_pkg::PMC_MODE_STANDBY |-> o_ctrl.bank_ret == ret_q && !o_ctrl.cpu_pwr_en)
    else $error("bad banks");
  a_off_all_down: assert property (low && mode_q == pmc_pkg::PMC_MODE_OFF |-> o_ctrl.bank_ret == 4'h0 && !o_ctrl.periph_pwr_en)
    else $error("off not down");
  a_timer_wake: assert property (low && mode_q != pmc_pkg::PMC_MODE_OFF && i_wake.lp_timer_evt && i_wake.lp_timer_wake_en && i_lp_timer_on |=> o_wake_evt)
    else $error("no timer wake");
  a_afe_follow: assert property (1'h1 |=> o_ctrl.afe_pwr_en == $past(i_afe_pwr_sw))
    else $error("afe moved");
  a_gate_follow: assert property (run |=> o_ctrl.periph_clk_en == ($past(i_periph_req) | $past(i_periph_activity)))
    else $error("bad gating");
endmodule

bind pmc_power_mode_ctrl pmc_chk u_chk (.i_clk_sys, .i_rst_n, .i_mode_req, .i_mode_sel, .i_bank_ret_sel,
  .i_afe_pwr_sw, .i_lp_timer_on, .i_periph_req, .i_periph_activity, .i_wake, .o_ctrl, .o_state, .o_wake_evt);

// [tb/tb_top.sv]
/*
  Bench for the power mode controller: reset, gating, cpu halt, deep states.
  Assumes the controller, its package, checker and far-side model.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: %0h, expected %0h", $time, (a), (e)); end end
  logic                  i_clk_sys = 1'h0;
  logic                  i_rst_n   = 1'h0;
  logic                  req       = 1'h0;
  logic                  afe       = 1'h0;
  logic                  tmr_on    = 1'h1;
  pmc_pkg::pmc_mode_t    sel       = pmc_pkg::PMC_MODE_RUN;
  logic [3:0]            ret       = 4'h0;
  logic [7:0]            preq      = 8'h00;
  logic [7:0]            pact      = 8'h00;
  pmc_pkg::pmc_wake_in_t wk;
  pmc_pkg::pmc_ctrl_t    ctl;
  pmc_pkg::pmc_state_t   st;
  logic                  evt;
  int                    n_mismatch = 0;
  int                    n_checks   = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  pmc_power_mode_ctrl dut (.i_clk_sys, .i_rst_n, .i_mode_req(req), .i_mode_sel(sel), .i_bank_ret_sel(ret),
    .i_afe_pwr_sw(afe), .i_lp_timer_on(tmr_on), .i_periph_req(preq), .i_periph_activity(pact),
    .i_wake(wk), .o_ctrl(ctl), .o_state(st), .o_wake_evt(evt));
  pmc_far_model u_far (.i_clk_sys, .o_wake(wk));
  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wait_st(input pmc_pkg::pmc_state_t s, input int lim, output int k);
    k = 0;
    #1;
    while (st !== s && k < lim) begin
      @(posedge i_clk_sys);
      #1;
      k++;
    end
    if (st !== s) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic ask(input pmc_pkg::pmc_mode_t m, input logic [3:0] r);
    @(posedge i_clk_sys);
    req <= 1'h1;
    sel <= m;
    ret <= r;
    @(posedge i_clk_sys);
    req <= 1'h0;
    #1;
  endtask
  task automatic t_reset;
    int k;
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'h1;
    `CHK({st, ctl.sys_init}, {pmc_pkg::PMC_ST_INIT, 1'h1})
    wait_st(pmc_pkg::PMC_ST_RUN, 300, k);
    `CHK(k, pmc_pkg::PMC_INIT_CYC)
  endtask
  task automatic t_gate;
    @(posedge i_clk_sys);
    preq <= 8'h81;
    pact <= 8'h10;
    @(posedge i_clk_sys);
    preq <= 8'h00;
    pact <= 8'h00;
    #1;
    `CHK(ctl.periph_clk_en, 8'h91)
    @(posedge i_clk_sys);
    #1;
    `CHK(ctl.periph_clk_en, 8'h00)
  endtask
  task automatic t_halt;
    int k;
    ask(pmc_pkg::PMC_MODE_RUN, 4'h0);
    `CHK(st, pmc_pkg::PMC_ST_RUN)
    ask(pmc_pkg::PMC_MODE_CPU_HALT, 4'h0);
    `CHK({st, ctl.cpu_clk_en, ctl.xfer_clk_en}, {pmc_pkg::PMC_ST_CPU_HALT, 2'h1})
    u_far.irq(3, 1'h1, 1'h0);
    repeat (3) @(posedge i_clk_sys);
    #1;
    `CHK(st, pmc_pkg::PMC_ST_CPU_HALT)
    u_far.irq(3, 1'h1, 1'h1);
    wait_st(pmc_pkg::PMC_ST_RUN, 2, k);
    `CHK(k, 1)
    u_far.irq(3, 1'h0, 1'h0);
  endtask
  task automatic t_deep(input pmc_pkg::pmc_mode_t m, input logic [3:0] r, input int p, input bit tm);
    int   k;
    logic rh;
    rh = m == pmc_pkg::PMC_MODE_RET_HALT;
    ask(m, r);
    wait_st(pmc_pkg::PMC_ST_LOW, 12, k);
    `CHK(k, pmc_pkg::PMC_OSC_CYC)
    `CHK({ctl.osc_en, ctl.xtal_en, ctl.cpu_pwr_en}, 3'h0)
    `CHK(ctl.bank_ret, rh ? 4'hF : m == pmc_pkg::PMC_MODE_STANDBY ? r : 4'h0)
    `CHK({ctl.pin_hold, ctl.periph_pwr_en, ctl.afe_pwr_en}, {rh, rh, afe})
    `CHK(ctl.lp_timer_run, tmr_on && m != pmc_pkg::PMC_MODE_OFF)
    if (m == pmc_pkg::PMC_MODE_OFF || !tmr_on) begin
      u_far.tmr_evt();
      repeat (3) @(posedge i_clk_sys);
      #1;
      `CHK(st, pmc_pkg::PMC_ST_LOW)
    end
    if (tm) begin
      u_far.tmr_evt();
    end else begin
      u_far.pin_edge(p, p[0]);
    end
    wait_st(pmc_pkg::PMC_ST_OSC_UP, 4, k);
    `CHK(evt, 1'h1)
    wait_st(pmc_pkg::PMC_ST_RUN, 300, k);
    `CHK(k, pmc_pkg::PMC_OSC_CYC + (rh ? pmc_pkg::PMC_RESUME_CYC : pmc_pkg::PMC_INIT_CYC))
  endtask
  initial begin
    t_reset();
    t_gate();
    t_halt();
    tmr_on <= 1'h0;
    t_deep(pmc_pkg::PMC_MODE_RET_HALT, 4'h0, 3, 1'h0);
    @(posedge i_clk_sys);
    afe    <= 1'h1;
    tmr_on <= 1'h1;
    t_deep(pmc_pkg::PMC_MODE_RET_HALT, 4'h0, 0, 1'h1);
    t_deep(pmc_pkg::PMC_MODE_STANDBY, 4'h5, 4, 1'h0);
    t_deep(pmc_pkg::PMC_MODE_STANDBY, 4'hA, 0, 1'h1);
    t_deep(pmc_pkg::PMC_MODE_OFF, 4'hF, 6, 1'h0);
    conclude();
  end
endmodule
